// ==== pkg/wdtu_pkg.sv ====
/*
 * Constants, register map and field layout of the watchdog timeout unit.
 * Assumes a single 25 MHz system clock and an 8-bit register port.
 */
// Function
// RULE1 - Awake timeout without clear requests reset
// RULE2 - Counter runs from 31 kHz oscillator
// RULE3 - Mode 11: always active, even asleep
// RULE4 - Mode 10: active awake, off asleep
// RULE5 - Mode 01: software enable bit decides
// RULE6 - Mode 00: always disabled
// RULE7 - Select n gives 2^(n+5); high codes 1:32
// RULE8 - Reset: select 01011, enable 0
// RULE9 - Count cleared by listed events
// RULE10 - Sleep-enabled count restarts, cleared at exit
// RULE11 - Crystal clock: held clear until startup ends
// RULE12 - Sleep timeout wakes, updates flags, no reset
// RULE13 - Divider select change leaves watchdog alone
// RULE14 - Control: 7-6 zero, 5-1 select, 0 enable
// RULE15 - Sleep wake: powerdown cleared, timeout set
// RULE16 - Held at zero while clearing persists
package wdtu_pkg;
    // Clock and oscillator figures
    localparam int SYS_CLK_HZ       = 25_000_000;
    localparam int LF_OSC_HZ        = 31_000;
    localparam int BASE_INTERVAL_US = 1_000;
    localparam int LF_TICK_CYCLES   = SYS_CLK_HZ / LF_OSC_HZ;

    // Counter and prescale layout
    localparam int          CNT_W         = 23;
    localparam int          SEL_W         = 5;
    localparam int          BASE_SHIFT    = 5;
    localparam logic [4:0]  SEL_MAX_VALID = 5'h12;
    localparam logic [4:0]  SEL_RESET     = 5'h0b;
    localparam logic        SWEN_RESET    = 1'h0;

    // Register port
    localparam int         ADDR_W    = 4;
    localparam int         DATA_W    = 8;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_EVT  = 4'h1;
    localparam logic [3:0] ADDR_MASK = 4'h2;
    localparam logic [3:0] ADDR_FLAG = 4'h3;

    // Control register fields
    localparam int SWEN_BIT = 0;
    localparam int SEL_LSB  = 1;
    localparam int SEL_MSB  = 5;

    // Event and flag bits
    localparam int EVT_RESET = 0;
    localparam int EVT_WAKE  = 1;
    localparam int EVT_W     = 2;
    localparam int FLAG_TO   = 0;
    localparam int FLAG_PD   = 1;
    localparam int FLAG_RC   = 2;

    // Mode configuration encodings
    typedef enum logic [1:0] {
        WDTU_MODE_OFF   = 2'h0,
        WDTU_MODE_SW    = 2'h1,
        WDTU_MODE_AWAKE = 2'h2,
        WDTU_MODE_ON    = 2'h3
    } wdtu_mode_type;
endpackage

// ==== pkg/wdtu_cnt_if.sv ====
/*
 * Interface joining oscillator synchroniser, prescale counter and control.
 * Assumes all members live on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface wdtu_cnt_if;
    import wdtu_pkg::*;
    logic             tick;
    logic             clear;
    logic [SEL_W-1:0] periodSel;
    logic             expire;
    logic [CNT_W-1:0] count;

    modport osc (output tick);
    modport cnt (input tick, input clear, input periodSel, output expire, output count);
    modport ctl (input tick, output clear, output periodSel, input expire, input count);
endinterface
`default_nettype wire

// ==== core/wdtu_osc_sync.sv ====
/*
 * Brings the low frequency oscillator pin into the system clock and emits
 * one pulse per rising edge. Assumes the oscillator is far slower than clk.
 */
`timescale 1ns/10ps
`default_nettype none
module wdtu_osc_sync
    import wdtu_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Oscillator pin
    input  wire logic lowFreqInternalOsc,
    // Tick toward the counter
    wdtu_cnt_if.osc   port
);
    logic syncA;
    logic syncB;
    logic syncPrev;

    // Two-stage synchroniser, then edge history
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            syncA    <= 1'h0;
            syncB    <= 1'h0;
            syncPrev <= 1'h0;
        end
        else
        begin
            syncA    <= lowFreqInternalOsc;
            syncB    <= syncA;
            syncPrev <= syncB;
        end
    end

    // One tick per oscillator period
    assign port.tick = syncB & ~syncPrev; // RULE2
endmodule
`default_nettype wire

// ==== core/wdtu_prescaler.sv ====
/*
 * Counts oscillator ticks up to the selected power-of-two period.
 * Assumes clear and periodSel come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module wdtu_prescaler
    import wdtu_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Counter port
    wdtu_cnt_if.cnt   port
);
    logic [CNT_W-1:0] count;

    // Last count value of a period
    function automatic logic [CNT_W-1:0] limitFor(input logic [SEL_W-1:0] sel);
        logic [CNT_W:0] one;
        one = {{CNT_W{1'h0}}, 1'h1};
        if (sel > SEL_MAX_VALID)
            limitFor = CNT_W'((one << BASE_SHIFT) - 1'h1); // RULE7
        else
            limitFor = CNT_W'((one << (int'(sel) + BASE_SHIFT)) - 1'h1); // RULE7
    endfunction

    // Clear holds at zero, wrap after expiry
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            count <= '0; // RULE9
        else if (port.clear)
            count <= '0; // RULE16
        else if (port.expire)
            count <= '0;
        else if (port.tick)
            count <= count + 1'h1; // RULE2
    end

    assign port.expire = port.tick & ~port.clear & (count == limitFor(port.periodSel));
    assign port.count  = count;

    property p_clear_zero;
        @(posedge clk) disable iff (!arst_n) port.clear |=> (count == '0);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("count not zero after clear"); // RULE16

    property p_short_period;
        @(posedge clk) disable iff (!arst_n)
        (port.expire && port.periodSel > SEL_MAX_VALID) |-> (count == CNT_W'(31));
    endproperty
    a_short_period: assert property (p_short_period) else $error("reserved select not 1:32"); // RULE7
endmodule
`default_nettype wire

// ==== core/wdtu_top.sv ====
/*
 * Watchdog timeout unit: mode decode, clearing, control register,
 * status flags, event interrupt and reset or wake request.
 * Assumes sleep, clear, fail and startup inputs come from logic on clk;
 * only the oscillator pin is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
module wdtu_top
    import wdtu_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Oscillator pin
    input  wire logic              lowFreqInternalOsc,
    // Device state
    input  wire logic [1:0]        watchdogModeConfig,
    input  wire logic              sleepMode,
    input  wire logic              watchdogClearInstruction,
    input  wire logic              oscFail,
    input  wire logic              crystalClock,
    input  wire logic              oscStartupTimer,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [DATA_W-1:0] regRdata,
    // Requests and flags
    output logic                   resetRequest,
    output logic                   wakeRequest,
    output logic                   timeoutStatusFlag,
    output logic                   powerdownStatusFlag,
    output logic                   watchdogResetCauseFlag,
    output logic                   irq
);
    wdtu_cnt_if cntBus ();

    logic [SEL_W-1:0]  timeoutPrescaleSelect;
    logic              softwareWatchdogEnable;
    logic [EVT_W-1:0]  evtStatus;
    logic [EVT_W-1:0]  evtMask;
    logic              sleepPrev;
    logic              active;
    logic              sleepEntry;
    logic              sleepExit;
    logic              ostHold;
    logic              wrCtrl;
    logic              wrEvt;
    logic              wrMask;
    logic              wrFlag;
    logic [EVT_W-1:0]  evtSet;
    logic [EVT_W-1:0]  next_evtStatus;

    wdtu_osc_sync u_sync (
        .clk                (clk),
        .arst_n             (arst_n),
        .lowFreqInternalOsc (lowFreqInternalOsc),
        .port               (cntBus)
    );

    wdtu_prescaler u_pre (
        .clk    (clk),
        .arst_n (arst_n),
        .port   (cntBus)
    );

    // Mode decode; the divider select is not an input, so it cannot disturb this
    always_comb
    begin
        case (wdtu_mode_type'(watchdogModeConfig))
            WDTU_MODE_ON:    active = 1'h1; // RULE3
            WDTU_MODE_AWAKE: active = ~sleepMode; // RULE4
            WDTU_MODE_SW:    active = softwareWatchdogEnable; // RULE5
            WDTU_MODE_OFF:   active = 1'h0; // RULE6
            default:         active = 1'h0;
        endcase
    end

    // Sleep edges
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sleepPrev <= 1'h0;
        else
            sleepPrev <= sleepMode;
    end

    assign sleepEntry = sleepMode & ~sleepPrev;
    assign sleepExit  = ~sleepMode & sleepPrev;
    assign ostHold    = crystalClock & oscStartupTimer & ~sleepMode; // RULE11

    // Clearing conditions; a disabled watchdog is held at zero
    assign cntBus.clear = watchdogClearInstruction | sleepEntry | sleepExit | oscFail
                        | ~active | ostHold; // RULE9 RULE10 RULE13
    assign cntBus.periodSel = timeoutPrescaleSelect;

    // Register write decode
    assign wrCtrl = regWrite && (regAddr == ADDR_CTRL);
    assign wrEvt  = regWrite && (regAddr == ADDR_EVT);
    assign wrMask = regWrite && (regAddr == ADDR_MASK);
    assign wrFlag = regWrite && (regAddr == ADDR_FLAG);

    // Control register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timeoutPrescaleSelect  <= SEL_RESET; // RULE8
            softwareWatchdogEnable <= SWEN_RESET; // RULE8
        end
        else if (wrCtrl)
        begin
            timeoutPrescaleSelect  <= regWdata[SEL_MSB:SEL_LSB]; // RULE14
            softwareWatchdogEnable <= regWdata[SWEN_BIT]; // RULE14
        end
    end

    // Timeout outcome: reset when awake, wake when asleep
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            resetRequest <= 1'h0;
            wakeRequest  <= 1'h0;
        end
        else
        begin
            resetRequest <= cntBus.expire & ~sleepMode; // RULE1
            wakeRequest  <= cntBus.expire & sleepMode; // RULE12
        end
    end

    // Timeout and powerdown flags
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timeoutStatusFlag   <= 1'h0;
            powerdownStatusFlag <= 1'h0;
        end
        else if (cntBus.expire)
        begin
            timeoutStatusFlag   <= 1'h1; // RULE12
            powerdownStatusFlag <= powerdownStatusFlag & ~sleepMode; // RULE15
        end
        else if (watchdogClearInstruction)
        begin
            timeoutStatusFlag   <= 1'h0;
            powerdownStatusFlag <= 1'h0;
        end
        else if (sleepEntry)
            powerdownStatusFlag <= 1'h1;
    end

    // Reset-cause flag, cleared by writing one; a new timeout wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            watchdogResetCauseFlag <= 1'h0;
        else if (cntBus.expire)
            watchdogResetCauseFlag <= 1'h1; // RULE12
        else if (wrFlag && regWdata[FLAG_RC])
            watchdogResetCauseFlag <= 1'h0;
    end

    // Sticky events, write one to clear, set wins
    assign evtSet = {cntBus.expire & sleepMode, cntBus.expire & ~sleepMode};

    always_comb
    begin
        next_evtStatus = evtStatus;
        if (wrEvt)
            next_evtStatus = evtStatus & ~regWdata[EVT_W-1:0];
        next_evtStatus = next_evtStatus | evtSet;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            evtStatus <= '0;
            evtMask   <= '0;
            irq       <= 1'h0;
        end
        else
        begin
            evtStatus <= next_evtStatus;
            irq       <= |(next_evtStatus & (wrMask ? regWdata[EVT_W-1:0] : evtMask));
            if (wrMask)
                evtMask <= regWdata[EVT_W-1:0];
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            regRdata <= '0;
        else if (regRead)
        begin
            case (regAddr)
                ADDR_CTRL: regRdata <= {2'h0, timeoutPrescaleSelect, softwareWatchdogEnable}; // RULE14
                ADDR_EVT:  regRdata <= {{(DATA_W-EVT_W){1'h0}}, evtStatus};
                ADDR_MASK: regRdata <= {{(DATA_W-EVT_W){1'h0}}, evtMask};
                ADDR_FLAG: regRdata <= {5'h0, watchdogResetCauseFlag, powerdownStatusFlag, timeoutStatusFlag};
                default:   regRdata <= '0;
            endcase
        end
        else
            regRdata <= '0;
    end

    property p_awake_reset;
        @(posedge clk) disable iff (!arst_n) (cntBus.expire && !sleepMode) |=> (resetRequest && !wakeRequest);
    endproperty
    a_awake_reset: assert property (p_awake_reset) else $error("awake timeout gave no reset"); // RULE1

    property p_sleep_wake;
        @(posedge clk) disable iff (!arst_n) (cntBus.expire && sleepMode) |=> (wakeRequest && !resetRequest);
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep timeout did not wake"); // RULE12

    property p_mode_on;
        @(posedge clk) disable iff (!arst_n) (watchdogModeConfig == 2'h3) |-> active;
    endproperty
    a_mode_on: assert property (p_mode_on) else $error("always-on mode inactive"); // RULE3

    property p_mode_awake;
        @(posedge clk) disable iff (!arst_n) (watchdogModeConfig == 2'h2) |-> (active == !sleepMode);
    endproperty
    a_mode_awake: assert property (p_mode_awake) else $error("awake-only mode wrong"); // RULE4

    property p_mode_sw;
        @(posedge clk) disable iff (!arst_n) (watchdogModeConfig == 2'h1) |-> (active == softwareWatchdogEnable);
    endproperty
    a_mode_sw: assert property (p_mode_sw) else $error("software mode ignores enable"); // RULE5

    property p_mode_off;
        @(posedge clk) disable iff (!arst_n) (watchdogModeConfig == 2'h0) |=> (cntBus.count == '0);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("off mode counted"); // RULE6

    property p_sleep_edge;
        @(posedge clk) disable iff (!arst_n) ($rose(sleepMode) || $fell(sleepMode)) |=> (cntBus.count == '0);
    endproperty
    a_sleep_edge: assert property (p_sleep_edge) else $error("sleep edge did not clear"); // RULE10

    property p_ctrl_read;
        @(posedge clk) disable iff (!arst_n)
        (regRead && regAddr == ADDR_CTRL && !regWrite) |=>
        (regRdata == {2'h0, $past(timeoutPrescaleSelect), $past(softwareWatchdogEnable)});
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong"); // RULE14

    property p_wake_flags;
        @(posedge clk) disable iff (!arst_n) (cntBus.expire && sleepMode) |=> (timeoutStatusFlag && !powerdownStatusFlag);
    endproperty
    a_wake_flags: assert property (p_wake_flags) else $error("wake flags not updated"); // RULE15

    property p_ost_hold;
        @(posedge clk) disable iff (!arst_n)
        (crystalClock && oscStartupTimer && !sleepMode) |=> (cntBus.count == '0);
    endproperty
    a_ost_hold: assert property (p_ost_hold) else $error("count ran during startup hold"); // RULE11

    property p_fail_clear;
        @(posedge clk) disable iff (!arst_n)
        oscFail |=> (cntBus.count == '0);
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("oscillator failure did not clear"); // RULE9

    property p_clr_instr;
        @(posedge clk) disable iff (!arst_n)
        watchdogClearInstruction |=> (cntBus.count == '0);
    endproperty
    a_clr_instr: assert property (p_clr_instr) else $error("clear instruction did not clear"); // RULE9

    property p_asleep_no_reset;
        @(posedge clk) disable iff (!arst_n)
        sleepMode |=> !resetRequest;
    endproperty
    a_asleep_no_reset: assert property (p_asleep_no_reset) else $error("reset requested in sleep"); // RULE12

    property p_awake_no_wake;
        @(posedge clk) disable iff (!arst_n)
        !sleepMode |=> !wakeRequest;
    endproperty
    a_awake_no_wake: assert property (p_awake_no_wake) else $error("wake requested while awake"); // RULE1

    property p_sel_write;
        @(posedge clk) disable iff (!arst_n)
        (regWrite && regAddr == ADDR_CTRL) |=> (timeoutPrescaleSelect == $past(regWdata[SEL_MSB:SEL_LSB]));
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("period select not written"); // RULE14

    property p_tick_only;
        @(posedge clk) disable iff (!arst_n)
        (!cntBus.clear && !cntBus.tick) |=> $stable(cntBus.count);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("count moved without a tick"); // RULE2

    property p_pd_set;
        @(posedge clk) disable iff (!arst_n)
        (sleepEntry && !watchdogClearInstruction) |=> powerdownStatusFlag;
    endproperty
    a_pd_set: assert property (p_pd_set) else $error("powerdown flag not set on sleep"); // RULE12

    property p_cause_set;
        @(posedge clk) disable iff (!arst_n)
        cntBus.expire |=> watchdogResetCauseFlag;
    endproperty
    a_cause_set: assert property (p_cause_set) else $error("reset cause flag not set"); // RULE12
endmodule
`default_nettype wire

// ==== tb/watchdog_timeout_unit_tb.sv ====
/*
 * Self-checking bench for the watchdog timeout unit top module.
 * Assumes the oscillator pin may toggle every 4 system clocks.
 */
`timescale 1ns/10ps
`default_nettype none
module watchdog_timeout_unit_tb;
    import wdtu_pkg::*;

    typedef struct {
        logic [1:0] mode;
        logic [7:0] ctrl;
        logic       sleep;
        int         n;
        logic       fire;
    } wdtu_row_type;

    localparam int LIMIT = 20000;

    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        osc = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic        sleep = 1'b0;
    logic        clr = 1'b0;
    logic        oscFail = 1'b0;
    logic        crystal = 1'b0;
    logic        osc_startup_timer = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWdata = 8'h00;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [7:0]  regRdata;
    logic        resetRequest;
    logic        wakeRequest;
    logic        toFlag;
    logic        pdFlag;
    logic        rcFlag;
    logic        irq;
    logic [7:0]  d;
    int          badCount = 0;
    int          nTests = 0;
    int          resetSeen = 0;
    int          wakeSeen = 0;
    int          cycles = 0;

    // Mode, control byte, sleep, ticks to expiry, expiry expected
    wdtu_row_type rows [0:10] = '{
        '{WDTU_MODE_ON,    8'h00, 1'b0, 32, 1'b1},
        '{WDTU_MODE_ON,    8'h00, 1'b1, 32, 1'b1},
        '{WDTU_MODE_AWAKE, 8'h00, 1'b0, 32, 1'b1},
        '{WDTU_MODE_AWAKE, 8'h01, 1'b1, 40, 1'b0},
        '{WDTU_MODE_SW,    8'h01, 1'b0, 32, 1'b1},
        '{WDTU_MODE_SW,    8'h01, 1'b1, 32, 1'b1},
        '{WDTU_MODE_SW,    8'h00, 1'b0, 40, 1'b0},
        '{WDTU_MODE_OFF,   8'h01, 1'b0, 40, 1'b0},
        '{WDTU_MODE_ON,    8'h02, 1'b0, 64, 1'b1},
        '{WDTU_MODE_ON,    8'h26, 1'b0, 32, 1'b1},
        '{WDTU_MODE_ON,    8'h3e, 1'b0, 32, 1'b1}
    };

    // Device under test
    wdtu_top DUT (
        .clk                      (clk),
        .arst_n                   (arst_n),
        .lowFreqInternalOsc       (osc),
        .watchdogModeConfig       (mode),
        .sleepMode                (sleep),
        .watchdogClearInstruction (clr),
        .oscFail                  (oscFail),
        .crystalClock             (crystal),
        .oscStartupTimer          (osc_startup_timer),
        .regAddr                  (regAddr),
        .regWdata                 (regWdata),
        .regWrite                 (regWrite),
        .regRead                  (regRead),
        .regRdata                 (regRdata),
        .resetRequest             (resetRequest),
        .wakeRequest              (wakeRequest),
        .timeoutStatusFlag        (toFlag),
        .powerdownStatusFlag      (pdFlag),
        .watchdogResetCauseFlag   (rcFlag),
        .irq                      (irq)
    );

    // 25 MHz system clock
    always #20 clk = ~clk;

    // Request pulse counters and hang guard
    always @(posedge clk)
    begin
        if (resetRequest === 1'b1) resetSeen++;
        if (wakeRequest === 1'b1) wakeSeen++;
        cycles++;
        if (cycles == LIMIT)
        begin
            badCount++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            badCount++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        q = regRdata;
    endtask

    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    task automatic clearPulse();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask

    // Oscillator rising edges, 8 system clocks apart
    task automatic ticks(input int k);
        repeat (k)
        begin
            @(posedge clk);
            osc <= 1'b1;
            repeat (4) @(posedge clk);
            osc <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    task automatic quiet(input int k);
        int r0;
        int w0;
        r0 = resetSeen;
        w0 = wakeSeen;
        ticks(k);
        check("early reset", resetSeen - r0, 0);
        check("early wake", wakeSeen - w0, 0);
    endtask

    // No request one tick short of expiry, then exactly the expected one
    task automatic runChk(input int n, input int expR, input int expW);
        int r0;
        int w0;
        quiet(n - 1);
        r0 = resetSeen;
        w0 = wakeSeen;
        ticks(1);
        check("reset request", resetSeen - r0, expR);
        check("wake request", wakeSeen - w0, expW);
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(ADDR_CTRL, d);
        check("control after reset", d, 8'h16);
        wr(ADDR_CTRL, 8'hff);
        rd(ADDR_CTRL, d);
        check("control readback", d, 8'h3f);
        wr(4'h9, 8'hff);
        rd(4'h9, d);
        check("unmapped read", d, 8'h00);
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk);
            mode <= rows[i].mode;
            sleep <= rows[i].sleep;
            wr(ADDR_CTRL, rows[i].ctrl);
            clearPulse();
            runChk(rows[i].n, rows[i].fire & ~rows[i].sleep, rows[i].fire & rows[i].sleep);
            rd(ADDR_FLAG, d);
            if (rows[i].fire)
            begin
                check("flags after timeout", d, 8'h05);
                check("timeout flag pin", toFlag, 1'b1);
                check("cause flag pin", rcFlag, 1'b1);
            end
            else
                check("timeout flag idle", toFlag, 1'b0);
        end
        // Sleep entry and exit restart the count
        @(posedge clk);
        mode <= WDTU_MODE_ON;
        sleep <= 1'b0;
        wr(ADDR_CTRL, 8'h00);
        clearPulse();
        ticks(20);
        @(posedge clk);
        sleep <= 1'b1;
        settle();
        check("powerdown flag", pdFlag, 1'b1);
        runChk(32, 0, 1);
        check("powerdown after wake", pdFlag, 1'b0);
        ticks(20);
        @(posedge clk);
        sleep <= 1'b0;
        runChk(32, 1, 0);
        // Clear instruction in mid count
        ticks(20);
        clearPulse();
        runChk(32, 1, 0);
        // Oscillator failure holds the count
        @(posedge clk);
        oscFail <= 1'b1;
        quiet(40);
        @(posedge clk);
        oscFail <= 1'b0;
        runChk(32, 1, 0);
        // Crystal start-up hold, then a non-crystal clock
        @(posedge clk);
        crystal <= 1'b1;
        osc_startup_timer <= 1'b1;
        quiet(40);
        @(posedge clk);
        osc_startup_timer <= 1'b0;
        runChk(32, 1, 0);
        @(posedge clk);
        crystal <= 1'b0;
        osc_startup_timer <= 1'b1;
        runChk(32, 1, 0);
        @(posedge clk);
        osc_startup_timer <= 1'b0;
        // Event status, mask and interrupt line
        wr(ADDR_MASK, 8'h01);
        settle();
        check("irq masked in", irq, 1'b1);
        wr(ADDR_EVT, 8'h01);
        rd(ADDR_EVT, d);
        check("event after clear", d, 8'h02);
        check("irq cleared", irq, 1'b0);
        wr(ADDR_MASK, 8'h02);
        settle();
        check("irq wake event", irq, 1'b1);
        wr(ADDR_EVT, 8'h02);
        settle();
        check("irq idle", irq, 1'b0);
        check("cause pin before clear", rcFlag, 1'b1);
        wr(ADDR_FLAG, 8'h04);
        rd(ADDR_FLAG, d);
        check("reset cause cleared", d[2], 1'b0);
        check("cause pin cleared", rcFlag, 1'b0);
        // Reset in mid count
        ticks(20);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(ADDR_CTRL, d);
        check("control after second reset", d, 8'h16);
        rd(ADDR_FLAG, d);
        check("flags after second reset", d, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        runChk(32, 1, 0);
        results();
    end
endmodule
`default_nettype wire
